// ---- hdl/jtp_port.sv ----
// test access port: state machine, instruction and data registers, output pin
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// - mode select sampled each rising test clock edge advances the state machine
// - serial data input captured on rising test clock edge into selected register
// - data output driven only in shift-instruction or shift-data, else released
// - data output changes on falling test clock edge
// - test reset low holds the state machine in reset
// - device reset alone leaves state machine and test registers untouched, but clears USER_DATA and re-enables pull-ups
// - one pull-up disable bit turns off mode, data-in and test-reset pull-ups
`timescale 1ns/100ps
`default_nettype none
`include "jtp_defines.svh"
module jtp_port
  import jtp_pkg::*;
(
  input  wire logic                   CLK,        // system clock
  input  wire logic                   RST_B,      // device reset
  input  wire logic                   CE,         // system clock enable
  input  wire logic                   TCK,        // test clock
  input  wire logic                   TRST_B,     // test reset
  input  wire jtp_link_s              LINK,       // mode select and data in
  input  wire logic                   PUD_JTAG,   // pull-up disable bit
  output logic                        TDO_O,      // data out level
  output logic                        TDO_OE,     // data out enable
  output logic                        PU_EN,      // pull-up enables
  output logic [`JTP_USER_W-1:0]      USER_DATA,  // user register, system domain
  output logic                        USER_STB    // user update event
);
  jtp_state_e                 state_reg;
  jtp_state_e                 state_next;
  logic [`JTP_IR_W-1:0]       ir_sh_reg;
  logic [`JTP_IR_W-1:0]       ir_reg;
  logic [`JTP_ID_W-1:0]       dr_sh_reg;
  logic [`JTP_USER_W-1:0]     user_reg;
  logic                       upd_tgl_reg;
  logic                       tdo_reg;
  logic                       tdo_oe_reg;
  logic                       sync1_reg;
  logic                       sync2_reg;
  logic                       sync3_reg;
  logic [`JTP_USER_W-1:0]     user_hold_reg;

  function automatic jtp_state_e tap_step(input jtp_state_e s, input logic m);
    case (s)
      JTP_RESET:  tap_step = m ? JTP_RESET  : JTP_IDLE;
      JTP_IDLE:   tap_step = m ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_DR: tap_step = m ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_CAP_DR: tap_step = m ? JTP_EX1_DR : JTP_SHF_DR;
      JTP_SHF_DR: tap_step = m ? JTP_EX1_DR : JTP_SHF_DR;
      JTP_EX1_DR: tap_step = m ? JTP_UPD_DR : JTP_PAU_DR;
      JTP_PAU_DR: tap_step = m ? JTP_EX2_DR : JTP_PAU_DR;
      JTP_EX2_DR: tap_step = m ? JTP_UPD_DR : JTP_SHF_DR;
      JTP_UPD_DR: tap_step = m ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_IR: tap_step = m ? JTP_RESET  : JTP_CAP_IR;
      JTP_CAP_IR: tap_step = m ? JTP_EX1_IR : JTP_SHF_IR;
      JTP_SHF_IR: tap_step = m ? JTP_EX1_IR : JTP_SHF_IR;
      JTP_EX1_IR: tap_step = m ? JTP_UPD_IR : JTP_PAU_IR;
      JTP_PAU_IR: tap_step = m ? JTP_EX2_IR : JTP_PAU_IR;
      JTP_EX2_IR: tap_step = m ? JTP_UPD_IR : JTP_SHF_IR;
      JTP_UPD_IR: tap_step = m ? JTP_SEL_DR : JTP_IDLE;
      default:    tap_step = JTP_RESET;
    endcase
  endfunction

  // ----------------------------------------
  // state machine, test clock domain
  // ----------------------------------------
  always_comb begin
    state_next = tap_step(state_reg, LINK.mode);
  end

  // only the test reset touches this domain
  always_ff @(posedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      state_reg <= JTP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  always_ff @(posedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      ir_sh_reg <= `JTP_IR_RESET;
    end else if (state_reg == JTP_CAP_IR) begin
      ir_sh_reg <= `JTP_IR_CAPTURE;
    end else if (state_reg == JTP_SHF_IR) begin
      ir_sh_reg <= {LINK.din, ir_sh_reg[`JTP_IR_W-1:1]};
    end
  end

  always_ff @(posedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      ir_reg <= `JTP_IR_RESET;
    end else if (state_reg == JTP_RESET) begin
      ir_reg <= `JTP_IR_RESET;
    end else if (state_reg == JTP_UPD_IR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_ff @(posedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      dr_sh_reg <= '0;
    end else if (state_reg == JTP_CAP_DR) begin
      case (ir_reg)
        `JTP_IR_IDCODE: dr_sh_reg <= `JTP_IDCODE;
        `JTP_IR_USER:   dr_sh_reg <= {{(`JTP_ID_W-`JTP_USER_W){1'b0}}, user_reg};
        default:        dr_sh_reg <= '0;
      endcase
    end else if (state_reg == JTP_SHF_DR) begin
      case (ir_reg)
        `JTP_IR_IDCODE: dr_sh_reg <= {LINK.din, dr_sh_reg[`JTP_ID_W-1:1]};
        `JTP_IR_USER:   dr_sh_reg <= {{(`JTP_ID_W-`JTP_USER_W){1'b0}}, LINK.din,
                                      dr_sh_reg[`JTP_USER_W-1:1]};
        default:        dr_sh_reg <= {{(`JTP_ID_W-1){1'b0}}, LINK.din};
      endcase
    end
  end

  always_ff @(posedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      user_reg    <= `JTP_USER_RESET;
      upd_tgl_reg <= 1'b0;
    end else if (state_reg == JTP_UPD_DR && ir_reg == `JTP_IR_USER) begin
      user_reg    <= dr_sh_reg[`JTP_USER_W-1:0];
      upd_tgl_reg <= ~upd_tgl_reg;
    end
  end

  // ----------------------------------------
  // data output on falling test clock
  // ----------------------------------------
  always_ff @(negedge TCK or negedge TRST_B) begin
    if (!TRST_B) begin
      tdo_reg    <= 1'b1;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_oe_reg <= (state_reg == JTP_SHF_IR) || (state_reg == JTP_SHF_DR);
      tdo_reg    <= (state_reg == JTP_SHF_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
    end
  end

  assign TDO_O  = tdo_reg;
  assign TDO_OE = tdo_oe_reg;

  // ----------------------------------------
  // system domain: pull-ups and user crossing
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PU_EN <= 1'b1;
    end else if (CE) begin
      PU_EN <= ~PUD_JTAG;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (CE) begin
      sync1_reg <= upd_tgl_reg;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // user_reg is stable for many system cycles after the toggle lands
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      user_hold_reg <= `JTP_USER_RESET;
      USER_STB      <= 1'b0;
    end else if (CE) begin
      USER_STB <= sync2_reg ^ sync3_reg;
      if (sync2_reg ^ sync3_reg) begin
        user_hold_reg <= user_reg;
      end
    end
  end

  assign USER_DATA = user_hold_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trst_holds_reset: assert property (@(posedge TCK) !TRST_B |-> state_reg == JTP_RESET)
    else $error("state not in reset under test reset");
  a_five_ones_reset: assert property (@(posedge TCK) disable iff (!TRST_B)
      LINK.mode [*5] |=> state_reg == JTP_RESET)
    else $error("five mode ones did not reach reset");
  a_mode_advances: assert property (@(posedge TCK) disable iff (!TRST_B)
      state_reg == JTP_IDLE && LINK.mode |=> state_reg == JTP_SEL_DR)
    else $error("mode select did not advance state");
  a_tdo_enable: assert property (@(posedge TCK) disable iff (!TRST_B)
      tdo_oe_reg == (state_reg == JTP_SHF_IR || state_reg == JTP_SHF_DR))
    else $error("data out driven outside shift");
  a_tdo_falling: assert property (@(negedge TCK) disable iff (!TRST_B)
      $rose(tdo_oe_reg) |-> $past(state_reg) == JTP_SHF_IR || $past(state_reg) == JTP_SHF_DR)
    else $error("data out enable changed wrongly");
  a_ir_shift_in: assert property (@(posedge TCK) disable iff (!TRST_B)
      state_reg == JTP_SHF_IR |=> ir_sh_reg[`JTP_IR_W-1] == $past(LINK.din))
    else $error("data input not captured");
  a_pullup_off: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && PUD_JTAG |=> !PU_EN)
    else $error("pull-ups not disabled");
  a_sys_reset_alone: assert property (@(posedge TCK) disable iff (!TRST_B)
      !RST_B && state_reg == JTP_IDLE && !LINK.mode |=> state_reg == JTP_IDLE)
    else $error("device reset disturbed state machine");

  c_shift_dr:  cover property (@(posedge TCK) state_reg == JTP_SHF_DR);
  c_update_ir: cover property (@(posedge TCK) state_reg == JTP_UPD_IR);
  c_user_stb:  cover property (@(posedge CLK) USER_STB);
endmodule
`default_nettype wire

// ---- hdl/jtp_defines.svh ----
// constants for the test access port block
`ifndef JTP_DEFINES_SVH
`define JTP_DEFINES_SVH
`define JTP_IR_W        4
`define JTP_IR_RESET    4'h1
`define JTP_IR_BYPASS   4'hF
`define JTP_IR_IDCODE   4'h1
`define JTP_IR_USER     4'h2
`define JTP_IR_CAPTURE  4'h1
`define JTP_USER_W      16
`define JTP_USER_RESET  16'h0000
// arbitrary identification value
`define JTP_IDCODE      32'h0000_0001
`define JTP_ID_W        32
`endif

// ---- hdl/jtp_pkg.sv ----
// types for the test access port block
package jtp_pkg;
  typedef enum logic [3:0] {
    JTP_RESET, JTP_IDLE, JTP_SEL_DR, JTP_CAP_DR, JTP_SHF_DR, JTP_EX1_DR, JTP_PAU_DR, JTP_EX2_DR,
    JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR, JTP_SHF_IR, JTP_EX1_IR, JTP_PAU_IR, JTP_EX2_IR, JTP_UPD_IR
  } jtp_state_e;
  typedef struct packed {
    logic mode;
    logic din;
  } jtp_link_s;
endpackage

// ---- verification/jtp_host.sv ----
// host model driving the test port pins
`timescale 1ns/100ps
`default_nettype none
module jtp_host
  import jtp_pkg::*;
(
  output logic      tck,    // test clock, still between frames
  output jtp_link_s link,   // mode select and data in
  input  wire logic tdo_o,  // data out level
  input  wire logic tdo_oe  // data out enable
);
  logic tdo;
  assign tdo = tdo_oe ? tdo_o : 1'b1; // released pin pulled high
  initial begin
    tck = 1'b0;
    link = '0;
  end
  task automatic step(input logic m, input logic d, output logic t);
    link.mode = m;
    link.din = d;
    #7.5;
    t = tdo;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask
  task automatic walk(input logic [7:0] ms, input int n);
    logic t;
    for (int i = 0; i < n; i++) step(ms[i], 1'b0, t);
  endtask
  task automatic scan(input logic ir, input logic [31:0] v, input int n, output logic [31:0] got);
    logic t;
    got = '0;
    #1.3;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], t);
      got[i] = t;
    end
    walk(8'h01, 2);
    link.din = ~link.din;
  endtask
endmodule
`default_nettype wire

// ---- verification/jtp_port_tb_top.sv ----
// self-checking bench for the test access port
`timescale 1ns/100ps
`default_nettype none
`include "jtp_defines.svh"
module jtp_port_tb_top;
  import jtp_pkg::*;
  logic        clk, rst_b, trst_b, pud_jtag, tck, tdo_o, tdo_oe, pu_en, user_stb;
  jtp_link_s   link;
  logic [15:0] user_data, last_user;
  logic [15:0] exp_q[$];
  int          mismatches, n_checks, cycles;
  jtp_port uut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .TCK(tck), .TRST_B(trst_b), .LINK(link),
    .PUD_JTAG(pud_jtag), .TDO_O(tdo_o), .TDO_OE(tdo_oe), .PU_EN(pu_en), .USER_DATA(user_data),
    .USER_STB(user_stb));
  jtp_host host (.tck(tck), .link(link), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // user updates arrive in the system domain
  always @(posedge clk) begin
    if (user_stb === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({16'h0, user_data}, {16'h0, exp_q.pop_front()});
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic user_scan();
    logic [31:0] got;
    logic [15:0] v;
    v = 16'($urandom);
    exp_q.push_back(v);
    host.scan(1'b0, {16'h0, v}, 16, got);
    check(got[15:0], last_user);
    last_user = v;
  endtask
  initial begin
    logic [31:0] got;
    logic [7:0]  bv;
    last_user = 16'h0000;
    rst_b = 1'b0;
    trst_b = 1'b0;
    pud_jtag = 1'b0;
    void'($urandom(15));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    trst_b <= 1'b1;
    @(posedge clk);
    check(pu_en, 1'b1);
    check(tdo_oe, 1'b0);
    pud_jtag <= 1'b1;
    repeat (4) @(posedge clk);
    check(pu_en, 1'b0);
    pud_jtag <= 1'b0;
    repeat (4) @(posedge clk);
    check(pu_en, 1'b1);
    host.walk(8'h1F, 6);
    host.scan(1'b0, 32'h0, 32, got);
    check(got, `JTP_IDCODE);
    host.scan(1'b1, `JTP_IR_BYPASS, 4, got);
    check(got[3:0], `JTP_IR_CAPTURE);
    bv = 8'($urandom);
    host.scan(1'b0, {24'h0, bv}, 8, got);
    check(got[7:0], {bv[6:0], 1'b0});
    host.scan(1'b1, `JTP_IR_USER, 4, got);
    check(got[3:0], `JTP_IR_CAPTURE);
    repeat (2) user_scan();
    repeat (8) @(posedge clk);
    rst_b <= 1'b0;
    host.walk(8'h00, 2);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(user_data, 16'h0000);
    user_scan();
    repeat (8) @(posedge clk);
    exp_q.push_back(16'h0000);
    trst_b <= 1'b0;
    @(posedge clk);
    trst_b <= 1'b1;
    host.walk(8'h00, 1);
    host.scan(1'b0, 32'h0, 32, got);
    check(got, `JTP_IDCODE);
    repeat (20) @(posedge clk);
    check(exp_q.size(), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
